/* File: rtl/wdtnmi_timer.sv */
// Watchdog timer raising a non-maskable interrupt, with its two registers
// What this block does
// - Enable rising loads counter and prescaler
// - Reload strobe while enabled loads both immediately
// - Zero count plus tick reloads; period N+1
// - Reload write while disabled only stores
// - Reload write while enabled waits for terminal
// - Prescale field selects divide by 2^value
// - Prescale used only when prescaler loads
// - Expiry flag set on expiry, read clears
// - Interrupt enable gates interrupt at expiry
// - Enable clear freezes prescaler and counter
// - Prescaler fed by core clock over four
// - Reload strobe self-clears; zero write ignored
// - Debug freeze stops timer in debug
// - Upper eight control bits read zero
// - Timer interrupt ORed with mode pin request
// - Interrupt shares vector at address 1e
// - Both resets clear control and status bits
// - Two 16-bit registers in data space
`timescale 1ns/1ps
module wdtnmi_timer (
  // Clock and resets
  input wire logic clk,
  input wire logic rstn,
  input wire logic soft_reset,
  // Register port from the core
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire wdtnmi_pkg::wdtnmi_word_t reg_wdata,
  output logic [wdtnmi_pkg::DATA_W-1:0] reg_rdata_q,
  // Core status and interrupt
  input wire logic debug_mode,
  input wire logic mode_c_pin,
  output logic nmi_q,
  output logic [15:0] nmi_vector_q
);
  import wdtnmi_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // ==========================================
  // State
  logic [2:0] prescale_select_q;
  logic expiry_flag_q;
  logic irq_enable_q;
  logic timer_enable_q;
  logic reload_strobe_q;
  logic debug_freeze_q;
  logic [DATA_W-1:0] reload_value_q;
  logic [DATA_W-1:0] count_q;
  logic [DATA_W-1:0] count_d;
  logic [PRESCALER_W-1:0] prescaler_q;
  logic [PRESCALER_W-1:0] prescaler_d;
  logic [1:0] core_div_q;
  logic timer_irq_q;
  logic [2:0] active_sel_q;
  logic [9:0] run_gap_q;

  // ==========================================
  // Decode
  logic cs_wr;
  logic rv_wr;
  logic cs_rd;
  logic enable_rise;
  logic strobe_load;
  logic sw_load;
  logic running;
  logic quarter_en;
  logic tick;
  logic expire;

  function automatic logic [PRESCALER_W-1:0] prescale_top(input logic [2:0] sel);
    prescale_top = PRESCALER_W'((8'h01 << sel) - 8'h01);
  endfunction

  assign cs_wr = reg_wr && (reg_sel == ADDR_CONTROL_STATUS);
  assign rv_wr = reg_wr && (reg_sel == ADDR_RELOAD_VALUE);
  assign cs_rd = reg_rd && (reg_sel == ADDR_CONTROL_STATUS);
  assign enable_rise = cs_wr && reg_wdata[BIT_TIMER_ENABLE] && !timer_enable_q;
  assign strobe_load = cs_wr && reg_wdata[BIT_RELOAD_STROBE] && timer_enable_q
                       && reg_wdata[BIT_TIMER_ENABLE];
  assign sw_load = enable_rise || strobe_load;
  assign running = timer_enable_q && !(debug_freeze_q && debug_mode);
  assign quarter_en = running && (core_div_q == CORE_DIV_LAST);
  assign tick = quarter_en && (prescaler_q == '0);
  assign expire = tick && (count_q == '0);

  // ==========================================
  // Control bits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prescale_select_q <= PRESCALE_RST;
      irq_enable_q <= 1'b0;
      timer_enable_q <= 1'b0;
      debug_freeze_q <= 1'b0;
    end else if (soft_reset) begin
      prescale_select_q <= PRESCALE_RST;
      irq_enable_q <= 1'b0;
      timer_enable_q <= 1'b0;
      debug_freeze_q <= 1'b0;
    end else if (cs_wr) begin
      prescale_select_q <= reg_wdata[PRESCALE_MSB:PRESCALE_LSB];
      irq_enable_q <= reg_wdata[BIT_IRQ_ENABLE];
      timer_enable_q <= reg_wdata[BIT_TIMER_ENABLE];
      debug_freeze_q <= reg_wdata[BIT_DEBUG_FREEZE];
    end
  end

  // Prescale in force between loads
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active_sel_q <= PRESCALE_RST;
    end else if (sw_load) begin
      active_sel_q <= reg_wdata[PRESCALE_MSB:PRESCALE_LSB];
    end else if (expire) begin
      active_sel_q <= prescale_select_q;
    end
  end

  // Strobe reads back one cycle only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reload_strobe_q <= 1'b0;
    end else if (soft_reset) begin
      reload_strobe_q <= 1'b0;
    end else begin
      reload_strobe_q <= cs_wr && reg_wdata[BIT_RELOAD_STROBE];
    end
  end

  // Expiry flag: a set in the cycle of a read wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      expiry_flag_q <= 1'b0;
    end else if (soft_reset) begin
      expiry_flag_q <= 1'b0;
    end else if (expire) begin
      expiry_flag_q <= 1'b1;
    end else if (cs_rd) begin
      expiry_flag_q <= 1'b0;
    end
  end

  // ==========================================
  // Reload value store
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reload_value_q <= RELOAD_RST;
    end else if (rv_wr) begin
      reload_value_q <= reg_wdata;
    end
  end

  // ==========================================
  // Core clock quarter divider
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      core_div_q <= 2'h0;
    end else if (sw_load || soft_reset) begin
      core_div_q <= 2'h0;
    end else if (running) begin
      core_div_q <= core_div_q + 2'h1;
    end
  end

  // ==========================================
  // Prescaler and counter
  always_comb begin
    prescaler_d = prescaler_q;
    count_d = count_q;
    if (sw_load) begin
      prescaler_d = prescale_top(reg_wdata[PRESCALE_MSB:PRESCALE_LSB]);
      count_d = reload_value_q;
    end else if (expire) begin
      prescaler_d = prescale_top(prescale_select_q);
      count_d = reload_value_q;
    end else if (tick) begin
      prescaler_d = prescale_top(active_sel_q);
      count_d = count_q - 16'h0001;
    end else if (quarter_en) begin
      prescaler_d = prescaler_q - 7'h01;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prescaler_q <= '0;
      count_q <= COUNT_RST;
    end else begin
      prescaler_q <= prescaler_d;
      count_q <= count_d;
    end
  end

  // ==========================================
  // Interrupt and vector
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timer_irq_q <= 1'b0;
    end else begin
      timer_irq_q <= expire && irq_enable_q;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nmi_q <= 1'b0;
    end else begin
      nmi_q <= timer_irq_q || mode_c_pin;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nmi_vector_q <= 16'h0000;
    end else begin
      nmi_vector_q <= NMI_VECTOR;
    end
  end

  // ==========================================
  // Read data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q <= '0;
    end else if (reg_rd) begin
      if (reg_sel == ADDR_CONTROL_STATUS) begin
        reg_rdata_q <= {RESERVED_READ, debug_freeze_q, reload_strobe_q,
                        timer_enable_q, irq_enable_q, expiry_flag_q,
                        prescale_select_q};
      end else begin
        reg_rdata_q <= reload_value_q;
      end
    end
  end

  // ==========================================
  // Checks
  // Running cycles since the last load or tick
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_gap_q <= '0;
    end else if (sw_load || tick) begin
      run_gap_q <= '0;
    end else if (running) begin
      run_gap_q <= run_gap_q + 10'h001;
    end
  end

  tick_spacing_a:
  assert property (tick |-> run_gap_q == 10'((CORE_DIV << active_sel_q) - 1))
    else $error("Tick spacing differs from prescale");

  enable_prescale_a:
  assert property (enable_rise
                   |=> prescaler_q == $past(prescale_top(reg_wdata[PRESCALE_MSB:PRESCALE_LSB])))
    else $error("Prescaler not loaded on enable rise");

  enable_load_a:
  assert property (enable_rise |=> count_q == $past(reload_value_q))
    else $error("Counter not loaded on enable rise");

  strobe_load_a:
  assert property (strobe_load |=> count_q == $past(reload_value_q)
                   && prescaler_q == $past(prescale_top(reg_wdata[2:0])))
    else $error("Reload strobe did not load timer");

  terminal_reload_a:
  assert property (expire && !sw_load |=> count_q == $past(reload_value_q))
    else $error("Terminal reload missed");

  running_stable_a:
  assert property (rv_wr && timer_enable_q && !tick && !sw_load
                   |=> count_q == $past(count_q))
    else $error("Reload write disturbed running count");

  expiry_set_a:
  assert property (expire && !soft_reset |=> expiry_flag_q)
    else $error("Expiry flag not set");

  read_clear_a:
  assert property (cs_rd && !expire |=> !expiry_flag_q)
    else $error("Expiry flag not cleared by read");

  irq_timing_a:
  assert property (expire && irq_enable_q |=> ##1 nmi_q)
    else $error("Interrupt not raised after expiry");

  irq_masked_a:
  assert property (expire && !irq_enable_q && !mode_c_pin ##1 !mode_c_pin |=> !nmi_q)
    else $error("Interrupt raised while disabled");

  disabled_freeze_a:
  assert property (!timer_enable_q && !cs_wr |=> $stable(count_q) && $stable(prescaler_q))
    else $error("Disabled timer moved");

  strobe_clear_a:
  assert property (reload_strobe_q && !cs_wr |=> !reload_strobe_q)
    else $error("Reload strobe stuck");

  debug_freeze_a:
  assert property (debug_freeze_q && debug_mode && !cs_wr
                   |=> $stable(count_q) && $stable(prescaler_q))
    else $error("Timer ran during debug freeze");

  reserved_zero_a:
  assert property (cs_rd |=> reg_rdata_q[15:8] == 8'h00)
    else $error("Reserved bits read nonzero");

  pin_or_a:
  assert property (mode_c_pin |=> nmi_q)
    else $error("Mode pin request not passed");

  soft_reset_a:
  assert property (soft_reset |=> !timer_enable_q && !irq_enable_q && !expiry_flag_q
                   && prescale_select_q == 3'h0 && !debug_freeze_q)
    else $error("Soft reset left control bits");

  soft_strobe_a:
  assert property (soft_reset |=> !reload_strobe_q)
    else $error("Soft reset left reload strobe");

  strobe_set_a:
  assert property (cs_wr && reg_wdata[BIT_RELOAD_STROBE] && !soft_reset |=> reload_strobe_q)
    else $error("Reload strobe not shown");

  disabled_store_a:
  assert property (rv_wr && !timer_enable_q
                   |=> reload_value_q == $past(reg_wdata) && count_q == $past(count_q))
    else $error("Disabled reload write moved counter");

  strobe_zero_a:
  assert property (cs_wr && timer_enable_q && reg_wdata[BIT_TIMER_ENABLE]
                   && !reg_wdata[BIT_RELOAD_STROBE] && !tick |=> count_q == $past(count_q))
    else $error("Zero strobe write moved counter");

  reload_read_a:
  assert property (reg_rd && reg_sel == ADDR_RELOAD_VALUE
                   |=> reg_rdata_q == $past(reload_value_q))
    else $error("Reload value read back wrong");

  vector_fixed_a:
  assert property ($past(rstn) |-> nmi_vector_q == NMI_VECTOR)
    else $error("Interrupt vector wrong");
endmodule

/* File: rtl/wdtnmi_pkg.sv */
// Constants shared by the watchdog timer with non-maskable interrupt
package wdtnmi_pkg;
  // ==========================================
  // Register word indices
  localparam logic ADDR_CONTROL_STATUS = 1'h0;
  localparam logic ADDR_RELOAD_VALUE = 1'h1;

  // ==========================================
  // Control/status field positions
  localparam int PRESCALE_LSB = 0;
  localparam int PRESCALE_MSB = 2;
  localparam int BIT_EXPIRY = 3;
  localparam int BIT_IRQ_ENABLE = 4;
  localparam int BIT_TIMER_ENABLE = 5;
  localparam int BIT_RELOAD_STROBE = 6;
  localparam int BIT_DEBUG_FREEZE = 7;

  // ==========================================
  // Widths and reset values
  localparam int DATA_W = 16;
  localparam int PRESCALER_W = 7;
  localparam logic [2:0] PRESCALE_RST = 3'h0;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [7:0] RESERVED_READ = 8'h00;

  // ==========================================
  // Core clock divide ahead of the prescaler, in cycles
  localparam int CORE_DIV = 4;
  localparam logic [1:0] CORE_DIV_LAST = 2'(CORE_DIV - 1);

  // ==========================================
  // Shared non-maskable exception vector
  localparam logic [15:0] NMI_VECTOR = 16'h001e;

  typedef logic [15:0] wdtnmi_word_t;
endpackage

/* File: testbench/wdtnmi_core_model.sv */
// Core-side model driving the watchdog register port
`timescale 1ns/1ps
module wdtnmi_core_model (
  // Clock
  input wire logic clk,
  // Register port toward the watchdog
  output logic reg_sel,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_wdata
);
  initial begin
    reg_sel = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  // ==========================================
  // Bus cycles, launched on the falling edge
  task automatic wr(input logic sel, input logic [15:0] data);
    @(negedge clk);
    reg_sel = sel;
    reg_wdata = sel ? data : {8'h00, data[7:0]};
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~reg_wdata;
    if (!sel && data[6]) begin
      repeat (2) @(negedge clk);
    end
  endtask
  task automatic rd(input logic sel);
    @(negedge clk);
    reg_sel = sel;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
  endtask
endmodule

/* File: testbench/wdtnmi_timer_tb.sv */
// Self-checking bench for the watchdog timer
`timescale 1ns/1ps
module wdtnmi_timer_tb;
  import wdtnmi_pkg::*;
  logic clk, rstn, soft_reset, debug_mode, mode_c_pin;
  logic reg_sel, reg_wr, reg_rd, nmi_q;
  logic [15:0] reg_wdata, reg_rdata_q, nmi_vector_q;
  logic rd_seen = 1'b0;
  logic nmi_last = 1'b0;
  int cyc = 0;
  int bad_count = 0;
  int compares = 0;
  int seed = 32'h4eaea15b;
  int k, n, p, per;
  logic [31:0] rd_exp[$];
  logic [31:0] nmi_exp[$];

  wdtnmi_timer dut_u (.clk(clk), .rstn(rstn), .soft_reset(soft_reset), .reg_sel(reg_sel),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .debug_mode(debug_mode), .mode_c_pin(mode_c_pin), .nmi_q(nmi_q),
    .nmi_vector_q(nmi_vector_q));
  wdtnmi_core_model core_u (.clk(clk), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================
  // Checking
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic cmp_read(input logic [31:0] exp);
    cmp("read", exp, {16'h0000, reg_rdata_q});
  endtask
  task automatic cmp_nmi(input logic [31:0] exp);
    cmp("nmi cycle", exp, cyc);
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic rd(input logic sel, input logic [15:0] exp);
    rd_exp.push_back({16'h0000, exp});
    core_u.rd(sel);
  endtask
  task automatic at(input int c);
    while (cyc < c) @(negedge clk);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    rd_seen <= reg_rd;
    if (cyc > 6000) begin
      bad_count++;
      close_out();
    end
  end
  always @(negedge clk) begin
    if (rd_seen) begin
      if (rd_exp.size() == 0) cmp_read(32'hffffffff);
      else cmp_read(rd_exp.pop_front());
    end
    if (nmi_q === 1'b1 && nmi_last !== 1'b1) begin
      if (nmi_exp.size() == 0) cmp_nmi(32'hffffffff);
      else cmp_nmi(nmi_exp.pop_front());
    end
    nmi_last <= nmi_q;
  end

  // ==========================================
  // Scenarios
  initial begin
    rstn = 1'b0;
    soft_reset = 1'b0;
    debug_mode = 1'b0;
    mode_c_pin = 1'b0;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    rd(1'b0, 16'h0000);
    rd(1'b1, RELOAD_RST);
    cmp("vector", {16'h0000, NMI_VECTOR}, {16'h0000, nmi_vector_q});
    for (int i = 0; i < 8; i++) begin
      core_u.wr(1'b0, 16'h0010 + 16'(i));
      rd(1'b0, 16'h0010 + 16'(i));
    end
    $display("register test done");
    for (int i = 0; i < 3; i++) begin
      n = 1 + ($random(seed) & 3);
      p = $random(seed) & 3;
      per = (n + 1) * 4 * (1 << p);
      core_u.wr(1'b1, 16'(n));
      core_u.wr(1'b0, 16'h0030 + 16'(p));
      k = cyc;
      nmi_exp.push_back(k + per + 1);
      nmi_exp.push_back(k + 2 * per + 1);
      at(k + 2 * per + 3);
      core_u.wr(1'b0, 16'h0010);
      rd(1'b0, 16'h0018);
      rd(1'b0, 16'h0010);
      $display("period test %0d done", i);
    end
    core_u.wr(1'b1, 16'h0001);
    core_u.wr(1'b0, 16'h0020);
    at(cyc + 19);
    core_u.wr(1'b0, 16'h0000);
    rd(1'b0, 16'h0008);
    $display("masked test done");
    core_u.wr(1'b1, 16'h0007);
    core_u.wr(1'b0, 16'h0030);
    at(cyc + 10);
    core_u.wr(1'b0, 16'h0071);
    k = cyc - 2;
    core_u.wr(1'b1, 16'h0000);
    core_u.wr(1'b0, 16'h0033);
    nmi_exp.push_back(k + 65);
    nmi_exp.push_back(k + 97);
    at(k + 98);
    rd(1'b0, 16'h003b);
    core_u.wr(1'b0, 16'h0000);
    $display("strobe test done");
    core_u.wr(1'b1, 16'h0001);
    core_u.wr(1'b0, 16'h0090);
    core_u.wr(1'b0, 16'h00b0);
    k = cyc;
    debug_mode = 1'b1;
    nmi_exp.push_back(k + 29);
    at(k + 20);
    debug_mode = 1'b0;
    at(k + 31);
    soft_reset = 1'b1;
    at(k + 32);
    soft_reset = 1'b0;
    rd(1'b0, 16'h0000);
    rd(1'b1, 16'h0001);
    $display("freeze and soft reset test done");
    k = cyc;
    mode_c_pin = 1'b1;
    nmi_exp.push_back(k + 1);
    at(k + 3);
    mode_c_pin = 1'b0;
    at(k + 50);
    cmp("pending nmi", 32'h0, 32'(nmi_exp.size() + rd_exp.size()));
    $display("mode pin test done");
    close_out();
  end
endmodule
